// ==== src/host_end.sv ====
// Host end of the link: runs one command per request and makes the link clock.
`timescale 1ns/1ps
module host_end (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire qmode_pkg::host_op_e cmd_op,
   input wire logic cmd_qpi,
   input wire logic cmd_xip,
   input wire logic [23:0] cmd_addr,
   input wire logic [7:0] cmd_mode,
   input wire logic [15:0] cmd_wdata,
   input wire logic [1:0] cmd_len,
   output logic rsp_valid,
   output logic [31:0] rsp_data,
   qspi_link_if.host link
);
   import qmode_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_INS = 3'b001,
      H_ADR = 3'b010,
      H_MOD = 3'b011,
      H_DUM = 3'b100,
      H_WR = 3'b101,
      H_RD = 3'b110,
      H_END = 3'b111
   } host_st_e;

   host_st_e st_ff, nxt_st, tgt;
   host_op_e op_ff, nxt_op;
   logic [3:0] div_ff, nxt_div;
   logic sck_ff, nxt_sck, csn_ff, nxt_csn, w_ff, nxt_w, qpi_ff, nxt_qpi;
   logic [23:0] addr_ff, nxt_addr;
   logic [7:0] mode_ff, nxt_mode;
   logic [15:0] wdata_ff, nxt_wdata;
   logic [1:0] len_ff, nxt_len;
   logic [5:0] cnt_ff, nxt_cnt, plen_ff, nxt_plen;
   logic [31:0] tx_ff, nxt_tx, rx_ff, nxt_rx, rsp_ff, nxt_rsp;
   logic [3:0] dqo_ff, nxt_dqo, dqoe_ff, nxt_dqoe, dq_s;
   logic rspv_ff, nxt_rspv, go, rise, fall;

   level_sync #(
      .WIDTH(4)
   ) u_dq_sync (
      .clk(core_clk),
      .nrst(nrst),
      .d(link.dq),
      .q(dq_s)
   );

   always_comb begin
      rise = (div_ff == SCK_HALF - 4'h1);
      fall = (div_ff == SCK_DIV - 4'h1);
      nxt_st = st_ff;
      nxt_op = op_ff;
      nxt_qpi = qpi_ff;
      nxt_addr = addr_ff;
      nxt_mode = mode_ff;
      nxt_wdata = wdata_ff;
      nxt_len = len_ff;
      nxt_div = (st_ff == H_IDLE || fall) ? 4'h0 : div_ff + 4'h1;
      nxt_sck = sck_ff;
      nxt_cnt = cnt_ff;
      nxt_plen = plen_ff;
      nxt_w = w_ff;
      nxt_tx = tx_ff;
      nxt_rx = rx_ff;
      nxt_rsp = rsp_ff;
      nxt_rspv = 1'b0;
      go = 1'b0;
      tgt = H_IDLE;
      case (st_ff)
         H_IDLE: begin
            if (cmd_valid) begin
               go = 1'b1;
               nxt_op = cmd_op;
               nxt_qpi = cmd_qpi;
               nxt_addr = cmd_addr;
               nxt_mode = cmd_mode;
               nxt_wdata = cmd_wdata;
               nxt_len = cmd_len;
               nxt_rx = 32'h00000000;
               // Continuous reads and the mode reset carry no instruction byte.
               tgt = ((cmd_op == HOP_MRST) || (cmd_xip && cmd_op == HOP_QREAD)) ? H_ADR : H_INS;
            end
         end
         H_END: begin
            if (fall) begin
               nxt_st = H_IDLE;
               nxt_rspv = 1'b1;
               nxt_rsp = rx_ff;
            end
         end
         default: begin
            if (rise) begin
               nxt_sck = 1'b1;
               if (st_ff == H_RD) begin
                  nxt_rx = w_ff ? {rx_ff[27:0], dq_s} : {rx_ff[30:0], dq_s[1]};
               end
            end
            if (fall) begin
               nxt_sck = 1'b0;
               nxt_cnt = cnt_ff + 6'h01;
               nxt_tx = w_ff ? {tx_ff[27:0], 4'h0} : {tx_ff[30:0], 1'b0};
               if (cnt_ff == plen_ff - 6'h01) begin
                  go = 1'b1;
                  case (st_ff)
                     H_INS: begin
                        case (op_ff)
                           HOP_RDSR1, HOP_RDSR2: tgt = H_RD;
                           HOP_WRSR: tgt = H_WR;
                           default: tgt = H_ADR;
                        endcase
                     end
                     H_ADR: begin
                        case (op_ff)
                           HOP_MRST: tgt = H_END;
                           HOP_RDCFG: tgt = H_RD;
                           HOP_WRCFG: tgt = H_WR;
                           HOP_QREAD: tgt = H_MOD;
                           default: tgt = H_DUM;
                        endcase
                     end
                     H_MOD: tgt = H_DUM;
                     H_DUM: tgt = H_RD;
                     default: tgt = H_END;
                  endcase
               end
            end
         end
      endcase
      if (go) begin
         nxt_st = tgt;
         nxt_cnt = 6'h00;
         nxt_w = nxt_qpi | ((tgt != H_INS) & ((nxt_op == HOP_QREAD) | (nxt_op == HOP_MRST)));
         nxt_tx = 32'h00000000;
         case (tgt)
            H_INS: begin
               nxt_plen = lane_clks(INS_BITS, nxt_w);
               case (nxt_op)
                  HOP_RDSR1: nxt_tx[31:24] = OP_RDSR1;
                  HOP_RDSR2: nxt_tx[31:24] = OP_RDSR2;
                  HOP_WRSR: nxt_tx[31:24] = OP_WRSR;
                  HOP_RDCFG: nxt_tx[31:24] = OP_RDCFG;
                  HOP_WRCFG: nxt_tx[31:24] = OP_WRCFG;
                  HOP_QREAD: nxt_tx[31:24] = OP_QREAD;
                  default: nxt_tx[31:24] = OP_SFDP;
               endcase
            end
            H_ADR: begin
               if (nxt_op == HOP_MRST) begin
                  nxt_plen = RESET_CLKS;
                  nxt_tx = {8{RESET_NIB}};
               end else begin
                  nxt_plen = lane_clks(ADDR_BITS, nxt_w);
                  nxt_tx[31:8] = nxt_addr;
               end
            end
            H_MOD: begin
               nxt_plen = MODE_CLKS;
               nxt_tx[31:24] = nxt_mode;
            end
            H_DUM: nxt_plen = (nxt_op == HOP_SFDP) ? SFDP_DUMMY : QREAD_DUMMY;
            H_WR: begin
               if (nxt_op == HOP_WRSR) begin
                  nxt_plen = lane_clks(WRSR_BITS, nxt_w);
                  nxt_tx[31:16] = nxt_wdata;
               end else begin
                  nxt_plen = lane_clks(BYTE_BITS, nxt_w);
                  nxt_tx[31:24] = nxt_wdata[7:0];
               end
            end
            H_RD: nxt_plen = lane_clks(6'(({4'h0, nxt_len} + 6'h01) << 3), nxt_w);
            default: nxt_plen = 6'h01;
         endcase
      end
      nxt_csn = (nxt_st == H_IDLE) || (nxt_st == H_END);
      // In single lane phases the hold and protect lines are held high, never released.
      case (nxt_st)
         H_INS, H_ADR, H_MOD, H_WR: begin
            nxt_dqo = nxt_w ? nxt_tx[31:28] : {3'b110, nxt_tx[31]};
            nxt_dqoe = nxt_w ? 4'hF : 4'hD;
         end
         H_DUM, H_RD: begin
            nxt_dqo = nxt_w ? 4'h0 : 4'hC;
            nxt_dqoe = nxt_w ? 4'h0 : 4'hD;
         end
         default: begin
            nxt_dqo = 4'h0;
            nxt_dqoe = 4'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= H_IDLE;
         op_ff <= HOP_RDSR1;
         qpi_ff <= 1'b0;
         addr_ff <= 24'h000000;
         mode_ff <= 8'h00;
         wdata_ff <= 16'h0000;
         len_ff <= 2'h0;
         div_ff <= 4'h0;
         sck_ff <= 1'b0;
         csn_ff <= 1'b1;
         cnt_ff <= 6'h00;
         plen_ff <= 6'h01;
         w_ff <= 1'b0;
         tx_ff <= 32'h00000000;
         rx_ff <= 32'h00000000;
         rsp_ff <= 32'h00000000;
         rspv_ff <= 1'b0;
         dqo_ff <= 4'h0;
         dqoe_ff <= 4'h0;
      end else begin
         st_ff <= nxt_st;
         op_ff <= nxt_op;
         qpi_ff <= nxt_qpi;
         addr_ff <= nxt_addr;
         mode_ff <= nxt_mode;
         wdata_ff <= nxt_wdata;
         len_ff <= nxt_len;
         div_ff <= nxt_div;
         sck_ff <= nxt_sck;
         csn_ff <= nxt_csn;
         cnt_ff <= nxt_cnt;
         plen_ff <= nxt_plen;
         w_ff <= nxt_w;
         tx_ff <= nxt_tx;
         rx_ff <= nxt_rx;
         rsp_ff <= nxt_rsp;
         rspv_ff <= nxt_rspv;
         dqo_ff <= nxt_dqo;
         dqoe_ff <= nxt_dqoe;
      end
   end

   assign cmd_ready = (st_ff == H_IDLE);
   assign rsp_valid = rspv_ff;
   assign rsp_data = rsp_ff;
   assign link.sck = sck_ff;
   assign link.cs_n = csn_ff;
   assign link.h_dq_o = dqo_ff;
   assign link.h_dq_oe = dqoe_ff;
endmodule : host_end

// ==== common/qmode_pkg.sv ====
// Shared constants, types and helpers for the quad mode link and both of its ends.
package qmode_pkg;
   // Instruction codes.
   localparam logic [7:0] OP_RDSR1 = 8'h05;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_RDCFG = 8'h65;
   localparam logic [7:0] OP_WRCFG = 8'h71;
   localparam logic [7:0] OP_QREAD = 8'hEB;
   localparam logic [7:0] OP_SFDP = 8'h5A;

   // Register addresses and field positions.
   localparam logic [23:0] CFG3_ADDR = 24'h800003;
   localparam int QPI_BIT = 6;
   localparam int QE_BIT = 1;
   localparam int BUSY_BIT = 0;

   // Mode byte values for continuous quad reads.
   localparam logic [7:0] MODE_ENTER = 8'hA5;
   localparam logic [7:0] MODE_EXIT = 8'h00;
   localparam logic [3:0] MODE_STAY_NIB = 4'hA;
   localparam logic [3:0] RESET_NIB = 4'hF;

   // Parameter word that describes the quad mode methods, and its table address.
   localparam logic [31:0] QPARAM_WORD = 32'hFF5DF68C;
   localparam logic [23:0] QPARAM_ADDR = 24'h000038;

   // Bit counts and link clock counts per phase.
   localparam logic [5:0] INS_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS = 6'h18;
   localparam logic [5:0] BYTE_BITS = 6'h08;
   localparam logic [5:0] WRSR_BITS = 6'h10;
   localparam logic [5:0] MODE_CLKS = 6'h02;
   localparam logic [5:0] SFDP_DUMMY = 6'h08;
   localparam logic [5:0] QREAD_DUMMY = 6'h04;
   localparam logic [5:0] RESET_CLKS = 6'h08;

   // Host link clock divider, in core clock cycles.
   localparam logic [3:0] SCK_HALF = 4'h4;
   localparam logic [3:0] SCK_DIV = SCK_HALF * 4'h2;

   // Values after reset.
   localparam logic QE_RST = 1'b0;
   localparam logic QPI_RST = 1'b0;
   localparam logic XIP_RST = 1'b0;

   typedef enum logic [2:0] {
      HOP_RDSR1 = 3'b000,
      HOP_RDSR2 = 3'b001,
      HOP_WRSR = 3'b010,
      HOP_RDCFG = 3'b011,
      HOP_WRCFG = 3'b100,
      HOP_QREAD = 3'b101,
      HOP_SFDP = 3'b110,
      HOP_MRST = 3'b111
   } host_op_e;

   // Clocks needed to move a number of bits over one or four lanes.
   function automatic logic [5:0] lane_clks(input logic [5:0] bits, input logic wide);
      return wide ? {2'b00, bits[5:2]} : bits;
   endfunction : lane_clks
endpackage : qmode_pkg

// ==== common/qspi_link_if.sv ====
// Quad serial link between the host end and the flash end.
`timescale 1ns/1ps
interface qspi_link_if;
   logic sck;
   logic cs_n;
   logic [3:0] h_dq_o;
   logic [3:0] h_dq_oe;
   logic [3:0] d_dq_o;
   logic [3:0] d_dq_oe;
   logic [3:0] dq;

   // Undriven lines float high as if pulled up.
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_dq
         assign dq[i] = h_dq_oe[i] ? h_dq_o[i] : (d_dq_oe[i] ? d_dq_o[i] : 1'b1);
      end
   endgenerate

   modport host (output sck, output cs_n, output h_dq_o, output h_dq_oe, input dq);
   modport flash (input sck, input cs_n, input dq, output d_dq_o, output d_dq_oe);
endinterface : qspi_link_if

// ==== src/level_sync.sv ====
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule : level_sync

// ==== src/flash_end.sv ====
// Flash end of the link: quad mode command interpreter clocked by the link clock.
`timescale 1ns/1ps
module flash_end (
   qspi_link_if.flash link,
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic core_busy,
   output logic quad_enable,
   output logic qpi_enable,
   output logic xip_active
);
   import qmode_pkg::*;

   typedef enum logic [2:0] {
      D_START = 3'b000,
      D_INS = 3'b001,
      D_ADR = 3'b010,
      D_MOD = 3'b011,
      D_DUM = 3'b100,
      D_WR = 3'b101,
      D_RD = 3'b110,
      D_IGN = 3'b111
   } dev_st_e;

   logic frm_rst_n, busy_s;
   dev_st_e st_ff, nxt_st, cur;
   logic [5:0] cnt_ff, nxt_cnt, plen;
   logic [7:0] op_ff, nxt_op, cop;
   logic [23:0] sh_ff, nxt_sh, sh_in;
   logic [23:0] addr_ff, nxt_addr, ld_addr;
   logic [7:0] tx_ff, nxt_tx, ld_byte, src;
   logic [3:0] out_ff, nxt_out, oe_ff, nxt_oe;
   logic [3:0] ffcnt_ff, nxt_ffcnt;
   logic ffbrk_ff, nxt_ffbrk, qe_ff, nxt_qe, qpi_ff, nxt_qpi;
   logic xip_ff, nxt_xip, wide, nwide, last, load;

   // Frame state is cleared by the frame's own select line, since the link clock stops
   // between frames and no edge can be counted on to end a frame.
   assign frm_rst_n = nrst & ~link.cs_n;

   // The busy level is only as fresh as the last two link clock edges.
   level_sync #(
      .WIDTH(1)
   ) u_busy_sync (
      .clk(link.sck),
      .nrst(nrst),
      .d(core_busy),
      .q(busy_s)
   );

   always_comb begin
      cur = (st_ff == D_START) ? (xip_ff ? D_ADR : D_INS) : st_ff;
      cop = (st_ff == D_START) ? OP_QREAD : op_ff;
      wide = qpi_ff | ((cur != D_INS) & (cop == OP_QREAD));
      sh_in = wide ? {sh_ff[19:0], link.dq} : {sh_ff[22:0], link.dq[0]};
      case (cur)
         D_INS: plen = lane_clks(INS_BITS, wide);
         D_ADR: plen = lane_clks(ADDR_BITS, wide);
         D_MOD: plen = MODE_CLKS;
         D_DUM: plen = (cop == OP_SFDP) ? SFDP_DUMMY : QREAD_DUMMY;
         D_WR: plen = lane_clks((cop == OP_WRSR) ? WRSR_BITS : BYTE_BITS, wide);
         D_RD: plen = lane_clks(BYTE_BITS, wide);
         default: plen = 6'h3F;
      endcase
      last = (cnt_ff == plen - 6'h01);
      nxt_st = cur;
      nxt_cnt = last ? 6'h00 : cnt_ff + 6'h01;
      nxt_op = cop;
      nxt_sh = sh_in;
      nxt_addr = addr_ff;
      nxt_tx = tx_ff;
      nxt_out = out_ff;
      nxt_oe = oe_ff;
      nxt_qe = qe_ff;
      nxt_qpi = qpi_ff;
      nxt_xip = xip_ff;
      load = 1'b0;
      ld_addr = addr_ff;
      case (cur)
         D_INS: begin
            if (last) begin
               nxt_op = sh_in[7:0];
               case (sh_in[7:0])
                  OP_RDSR1, OP_RDSR2: begin
                     nxt_st = D_RD;
                     load = 1'b1;
                  end
                  OP_WRSR: nxt_st = D_WR;
                  OP_RDCFG, OP_WRCFG, OP_SFDP: nxt_st = D_ADR;
                  // Quad reads are refused until quad lanes are enabled.
                  OP_QREAD: nxt_st = (qe_ff | qpi_ff) ? D_ADR : D_IGN;
                  default: nxt_st = D_IGN;
               endcase
            end
         end
         D_ADR: begin
            if (last) begin
               nxt_addr = sh_in;
               ld_addr = sh_in;
               case (cop)
                  OP_RDCFG: begin
                     nxt_st = D_RD;
                     load = 1'b1;
                  end
                  OP_WRCFG: nxt_st = D_WR;
                  OP_QREAD: nxt_st = D_MOD;
                  default: nxt_st = D_DUM;
               endcase
            end
         end
         D_MOD: begin
            if (last) begin
               nxt_st = D_DUM;
               // A5h and every other Ax keep the next frame instruction-less; 00h or
               // anything else drops back to instruction frames once this read ends.
               nxt_xip = (sh_in[7:4] == MODE_STAY_NIB) & (qe_ff | qpi_ff);
            end
         end
         D_DUM: begin
            if (last) begin
               nxt_st = D_RD;
               load = 1'b1;
            end
         end
         D_WR: begin
            if (last) begin
               nxt_st = D_IGN;
               if (cop == OP_WRSR) begin
                  nxt_qe = sh_in[QE_BIT];
               end else if (addr_ff == CFG3_ADDR) begin
                  nxt_qpi = sh_in[QPI_BIT];
               end
            end
         end
         D_RD: begin
            if (last) begin
               load = 1'b1;
               if ((cop == OP_QREAD) || (cop == OP_SFDP)) begin
                  ld_addr = addr_ff + 24'h000001;
                  nxt_addr = ld_addr;
               end
            end
         end
         default: begin
            nxt_cnt = cnt_ff;
         end
      endcase

      // Leading all-ones clocks on the four lanes, counted from the start of the frame.
      nxt_ffcnt = ffcnt_ff;
      nxt_ffbrk = ffbrk_ff;
      if (!ffbrk_ff) begin
         if (link.dq != RESET_NIB) begin
            nxt_ffbrk = 1'b1;
         end else if (ffcnt_ff == RESET_CLKS[3:0] - 4'h1) begin
            nxt_ffbrk = 1'b1;
            nxt_xip = 1'b0;
            nxt_st = D_IGN;
            load = 1'b0;
            nxt_oe = 4'h0;
         end else begin
            nxt_ffcnt = ffcnt_ff + 4'h1;
         end
      end

      ld_byte = 8'h00;
      case (nxt_op)
         OP_RDSR1: ld_byte[BUSY_BIT] = busy_s;
         OP_RDSR2: ld_byte[QE_BIT] = qe_ff;
         OP_RDCFG: ld_byte[QPI_BIT] = (ld_addr == CFG3_ADDR) & qpi_ff;
         OP_SFDP: begin
            ld_byte = 8'hFF;
            if (ld_addr[23:2] == QPARAM_ADDR[23:2]) begin
               ld_byte = QPARAM_WORD[{ld_addr[1:0], 3'b000} +: 8];
            end
         end
         // The array is modelled by returning the low address byte.
         default: ld_byte = ld_addr[7:0];
      endcase

      nwide = qpi_ff | (nxt_op == OP_QREAD);
      src = load ? ld_byte : tx_ff;
      if (load || (nxt_st == D_RD && cur == D_RD)) begin
         nxt_out = nwide ? src[7:4] : {2'b00, src[7], 1'b0};
         nxt_tx = nwide ? {src[3:0], 4'h0} : {src[6:0], 1'b0};
         nxt_oe = nwide ? 4'hF : 4'h2;
      end
   end

   always_ff @(posedge link.sck or negedge frm_rst_n) begin
      if (!frm_rst_n) begin
         st_ff <= D_START;
         cnt_ff <= 6'h00;
         op_ff <= 8'h00;
         sh_ff <= 24'h000000;
         addr_ff <= 24'h000000;
         tx_ff <= 8'h00;
         out_ff <= 4'h0;
         oe_ff <= 4'h0;
         ffcnt_ff <= 4'h0;
         ffbrk_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         op_ff <= nxt_op;
         sh_ff <= nxt_sh;
         addr_ff <= nxt_addr;
         tx_ff <= nxt_tx;
         out_ff <= nxt_out;
         oe_ff <= nxt_oe;
         ffcnt_ff <= nxt_ffcnt;
         ffbrk_ff <= nxt_ffbrk;
      end
   end

   // Mode flags survive frames; quad enable, the 4-4-4 setting and continuous read are all volatile and cleared by reset.
   always_ff @(posedge link.sck or negedge nrst) begin
      if (!nrst) begin
         qe_ff <= QE_RST;
         qpi_ff <= QPI_RST;
         xip_ff <= XIP_RST;
      end else begin
         qe_ff <= nxt_qe;
         qpi_ff <= nxt_qpi;
         xip_ff <= nxt_xip;
      end
   end

   assign link.d_dq_o = out_ff;
   assign link.d_dq_oe = oe_ff;

   level_sync #(
      .WIDTH(3)
   ) u_flag_sync (
      .clk(core_clk),
      .nrst(nrst),
      .d({xip_ff, qpi_ff, qe_ff}),
      .q({xip_active, qpi_enable, quad_enable})
   );
endmodule : flash_end

// ==== verification/quad_mode_entry_exit_control_asserts.sv ====
// Checker on the quad serial link and the flash end's mode flags.
`timescale 1ns/1ps
module quad_mode_entry_exit_control_asserts (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] h_dq_o,
   input wire logic [3:0] h_dq_oe,
   input wire logic [3:0] d_dq_oe,
   input wire logic quad_enable,
   input wire logic qpi_enable,
   input wire logic xip_active
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   a_sck_framed: assert property (cs_n |-> !sck)
      else $error("link clock runs outside a frame");
   a_sck_high: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
      else $error("link clock high phase is not four cycles");
   a_sck_low: assert property ($fell(sck) |-> !sck [*4])
      else $error("link clock low phase is short");
   a_frame_start: assert property ($fell(cs_n) |-> !sck [*4] ##1 sck)
      else $error("first link clock edge misplaced");
   a_host_idle: assert property (cs_n |-> h_dq_oe == 4'h0)
      else $error("host drives data lines between frames");
   a_flash_idle: assert property (cs_n && $past(cs_n) |-> d_dq_oe == 4'h0)
      else $error("flash drives data lines between frames");
   a_hold_high: assert property (h_dq_oe == 4'hD |-> h_dq_o[3:2] == 2'b11)
      else $error("hold or protect line released in single lane");
   a_xip_needs_qe: assert property (xip_active |-> quad_enable || qpi_enable)
      else $error("continuous read active without quad enable");

   // Main scenarios: entering and leaving continuous reads, enabling 4-4-4.
   c_xip_enter: cover property ($rose(xip_active));
   c_xip_leave: cover property ($fell(xip_active));
   c_qpi_on: cover property ($rose(qpi_enable));
endmodule : quad_mode_entry_exit_control_asserts

// ==== verification/quad_mode_entry_exit_control_tb.sv ====
// Self-checking bench for the host and flash ends joined by the quad link.
`timescale 1ns/1ps
module quad_mode_entry_exit_control_tb;
   import qmode_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b1;
   logic cmd_valid = 1'b0;
   logic core_busy = 1'b0;
   host_op_e cmd_op = HOP_RDSR1;
   logic cmd_qpi = 1'b0;
   logic cmd_xip = 1'b0;
   logic [23:0] cmd_addr = 24'h0;
   logic [7:0] cmd_mode = 8'h0;
   logic [15:0] cmd_wdata = 16'h0;
   logic [1:0] cmd_len = 2'h0;
   logic cmd_ready;
   logic rsp_valid;
   logic [31:0] rsp_data;
   logic quad_enable;
   logic qpi_enable;
   logic xip_active;
   logic [7:0] modes [4];
   int num_errors = 0;
   int compares = 0;
   int qe = 0;
   int qpi = 0;
   int xip = 0;
   int i;

   qspi_link_if link ();

   always #2.5 core_clk = ~core_clk;

   host_end u_host_end (.core_clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_qpi,
      .cmd_xip, .cmd_addr, .cmd_mode, .cmd_wdata, .cmd_len, .rsp_valid, .rsp_data,
      .link(link));
   flash_end u_flash_end (.link(link), .core_clk, .nrst, .core_busy, .quad_enable,
      .qpi_enable, .xip_active);
   quad_mode_entry_exit_control_asserts u_quad_mode_entry_exit_control_asserts (
      .core_clk, .nrst, .sck(link.sck), .cs_n(link.cs_n), .h_dq_o(link.h_dq_o),
      .h_dq_oe(link.h_dq_oe), .d_dq_oe(link.d_dq_oe), .quad_enable, .qpi_enable,
      .xip_active);

   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   // Runs one command and checks it against the reference state held in qe, qpi and xip.
   task automatic cmd(host_op_e op, logic [23:0] a, logic [7:0] m, logic [15:0] wd,
      logic [1:0] n);
      logic [31:0] e;
      logic [31:0] w;
      int k;
      int j;
      logic [7:0] exp_q [$];
      w = 32'hFF5DF68C;
      e = 32'h0;
      for (k = 0; k <= int'(n); k++) begin
         j = int'(a) + k - 56;
         if (op == HOP_SFDP)
            exp_q.push_back((j >= 0 && j < 4) ? w[8*j +: 8] : 8'hFF);
         if (op == HOP_QREAD)
            exp_q.push_back((qe || qpi) ? 8'(int'(a) + k) : 8'hFF);
      end
      // The first byte on the link ends up in the highest used byte of the response.
      while (exp_q.size() > 0)
         e = {e[23:0], exp_q.pop_front()};
      if (op == HOP_RDSR1)
         e = {31'h0, core_busy};
      if (op == HOP_RDSR2)
         e = 32'(qe << 1);
      if (op == HOP_RDCFG)
         e = (a == CFG3_ADDR) ? 32'(qpi << 6) : 32'h0;
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_qpi = qpi[0];
      cmd_xip = xip[0] && op == HOP_QREAD;
      cmd_addr = a;
      cmd_mode = m;
      cmd_wdata = wd;
      cmd_len = n;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      chk("cmd_ready", 32'h0, {31'h0, cmd_ready});
      k = 0;
      while (rsp_valid !== 1'b1 && k < 2000) begin
         @(negedge core_clk);
         k++;
      end
      chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
      chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
      if (!(op inside {HOP_WRSR, HOP_WRCFG, HOP_MRST}))
         chk("rsp_data", e, rsp_data);
      if (op == HOP_WRSR)
         qe = int'(wd[1]);
      if (op == HOP_WRCFG && a == CFG3_ADDR)
         qpi = int'(wd[6]);
      if (op == HOP_QREAD)
         xip = int'((qe || qpi) && m[7:4] == 4'hA);
      if (op == HOP_MRST)
         xip = 0;
      repeat (3) @(negedge core_clk);
      chk("quad_enable", qe, {31'h0, quad_enable});
      chk("qpi_enable", qpi, {31'h0, qpi_enable});
      // The flag follows the mode byte at once; only the frame format changes at the next frame.
      chk("xip_active", xip, {31'h0, xip_active});
   endtask : cmd

   initial begin
      void'($urandom(32'hBF77));
      // Reset falls just after time zero so that every asynchronous reset branch sees an edge.
      #1;
      nrst = 1'b0;
      repeat (3) @(negedge core_clk);
      nrst = 1'b1;
      cmd(HOP_SFDP, 24'h38, 8'h0, 16'h0, 2'h3);
      cmd(HOP_SFDP, 24'h3A, 8'h0, 16'h0, 2'h3);
      repeat (4) begin
         core_busy = 1'($urandom);
         cmd(HOP_RDSR1, 24'h0, 8'h0, 16'h0, 2'h0);
      end
      cmd(HOP_QREAD, 24'($urandom), MODE_ENTER, 16'h0, 2'h3);
      cmd(HOP_RDSR2, 24'h0, 8'h0, 16'h0, 2'h0);
      for (i = 0; i < 3; i++) begin
         cmd(HOP_WRSR, 24'h0, 8'h0, {14'($urandom), i != 1, 1'($urandom)}, 2'h0);
         cmd(HOP_RDSR2, 24'h0, 8'h0, 16'h0, 2'h0);
      end
      modes = '{8'hA5, {4'hA, 4'($urandom)}, {4'hA, 4'($urandom)}, 8'h00};
      for (i = 0; i < 4; i++)
         cmd(HOP_QREAD, 24'($urandom), modes[i], 16'h0, 2'($urandom));
      cmd(HOP_RDSR1, 24'h0, 8'h0, 16'h0, 2'h0);
      cmd(HOP_QREAD, 24'($urandom), MODE_ENTER, 16'h0, 2'h1);
      cmd(HOP_MRST, 24'h0, 8'h0, 16'h0, 2'h0);
      cmd(HOP_RDSR1, 24'h0, 8'h0, 16'h0, 2'h0);
      cmd(HOP_RDCFG, CFG3_ADDR - 24'h1, 8'h0, 16'h0, 2'h0);
      cmd(HOP_RDCFG, CFG3_ADDR, 8'h0, 16'h0, 2'h0);
      cmd(HOP_WRCFG, CFG3_ADDR, 8'h0, 16'h0040, 2'h0);
      cmd(HOP_RDCFG, CFG3_ADDR, 8'h0, 16'h0, 2'h0);
      cmd(HOP_RDSR2, 24'h0, 8'h0, 16'h0, 2'h0);
      cmd(HOP_QREAD, 24'($urandom), MODE_EXIT, 16'h0, 2'h2);
      cmd(HOP_WRCFG, CFG3_ADDR, 8'h0, 16'h0000, 2'h0);
      cmd(HOP_RDSR2, 24'h0, 8'h0, 16'h0, 2'h0);
      summarize();
   end

   // Thirty commands of about a microsecond each; over six times that cuts a hang.
   initial begin
      #200000;
      num_errors++;
      summarize();
   end
endmodule : quad_mode_entry_exit_control_tb
